// file: rtl/memmap_decoder.sv
/*
 * Memory map address decoder with registered region selects and
 * the stack pointer that feeds the stack window.
 * Assumes the address is stable one cycle ahead of use by the core.
 */
`timescale 1ns/1ns
// What this block does
// - Thirteen-bit address; each access picks exactly one region or none.
// - 0x0B00 to 0x1EFF selects user program ROM.
// - 0x1FF0 to 0x1FFF selects the user vector area.
// - 0x1F00 to 0x1FEF selects self-check ROM and vectors.
// - 0x0080 to 0x01FF selects user RAM.
// - Stack pointer starts at 0x00FF.
// - Stack addresses stay within 0x00C0 to 0x00FF.
module memmap_decoder
	import memmap_pkg::*;
(
	input  wire logic              CORE_CLK_I,
	input  wire logic              RST_I,
	input  wire logic [ADDR_W-1:0] ADDR_I,
	input  wire logic              ACCESS_I,
	input  wire sp_op_type         SP_OP_I,
	output logic                   ROM_SEL_O,
	output logic                   VEC_SEL_O,
	output logic                   CHK_SEL_O,
	output logic                   RAM_SEL_O,
	output logic                   IO_SEL_O,
	output logic                   ILLEGAL_O,
	output logic [ADDR_W-1:0]      SP_ADDR_O
);
	// ****************************************
	// Region decode
	// ****************************************
	wire logic [ADDR_W-1:0] sp_addr;
	wire logic              hit_rom = in_range(ADDR_I, ROM_LO, ROM_HI);
	wire logic              hit_vec = in_range(ADDR_I, VEC_LO, VEC_HI);
	wire logic              hit_chk = in_range(ADDR_I, CHK_LO, CHK_HI);
	wire logic              hit_ram = in_range(ADDR_I, RAM_LO, RAM_HI);
	wire logic              hit_io  = in_range(ADDR_I, IO_LO, IO_HI);
	wire logic              hit_any = hit_rom | hit_vec | hit_chk | hit_ram | hit_io;

	// ****************************************
	// Next select values
	// ****************************************
	// A select only rises for a valid access
	wire logic              rom_sel_d = ACCESS_I & hit_rom;
	wire logic              vec_sel_d = ACCESS_I & hit_vec;
	wire logic              chk_sel_d = ACCESS_I & hit_chk;
	wire logic              ram_sel_d = ACCESS_I & hit_ram;
	wire logic              io_sel_d  = ACCESS_I & hit_io;
	wire logic              ill_d     = ACCESS_I & ~hit_any;

	// ****************************************
	// Stack pointer
	// ****************************************
	stack_ptr u_sp (
		.clk_i     (CORE_CLK_I),
		.rst_i     (RST_I),
		.op_i      (SP_OP_I),
		.sp_addr_o (sp_addr)
	);

	// Registered selects, all cleared when idle
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			ROM_SEL_O <= 1'b0;
			VEC_SEL_O <= 1'b0;
			CHK_SEL_O <= 1'b0;
			RAM_SEL_O <= 1'b0;
			IO_SEL_O  <= 1'b0;
			ILLEGAL_O <= 1'b0;
		end
		else
		begin
			ROM_SEL_O <= rom_sel_d;
			VEC_SEL_O <= vec_sel_d;
			CHK_SEL_O <= chk_sel_d;
			RAM_SEL_O <= ram_sel_d;
			IO_SEL_O  <= io_sel_d;
			ILLEGAL_O <= ill_d;
		end
	end

	// Stack address copy
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			SP_ADDR_O <= {STACK_UPPER, SP_RESET};
		else
			SP_ADDR_O <= sp_addr;
	end

	// ****************************************
	// Checks
	// ****************************************
	wire logic [5:0] sel_vec = {ROM_SEL_O, VEC_SEL_O, CHK_SEL_O, RAM_SEL_O, IO_SEL_O, ILLEGAL_O};

	// At most one select per cycle, counting the illegal flag
	property p_onehot;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		$onehot0(sel_vec);
	endproperty
	a_onehot: assert property (p_onehot) else $error("more than one select");

	// No valid access, no select and no flag
	property p_idle;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		!ACCESS_I |=> sel_vec == '0;
	endproperty
	a_idle: assert property (p_idle) else $error("select without access");

	// ****************************************
	// Forward region checks
	// ****************************************
	// A valid access inside a region raises that region's select
	property p_rom;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		ACCESS_I && ADDR_I >= ROM_LO && ADDR_I <= ROM_HI |=> ROM_SEL_O;
	endproperty
	a_rom: assert property (p_rom) else $error("rom not selected");

	property p_vec;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		ACCESS_I && ADDR_I >= VEC_LO |=> VEC_SEL_O;
	endproperty
	a_vec: assert property (p_vec) else $error("vectors not selected");

	property p_chk;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		ACCESS_I && ADDR_I >= CHK_LO && ADDR_I <= CHK_HI |=> CHK_SEL_O;
	endproperty
	a_chk: assert property (p_chk) else $error("self-check not selected");

	property p_ram;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		ACCESS_I && ADDR_I >= RAM_LO && ADDR_I <= RAM_HI |=> RAM_SEL_O;
	endproperty
	a_ram: assert property (p_ram) else $error("ram not selected");

	// The low I/O block is legal and is not flagged
	property p_io;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		ACCESS_I && ADDR_I <= IO_HI |=> IO_SEL_O && !ILLEGAL_O;
	endproperty
	a_io: assert property (p_io) else $error("io access flagged");

	// ****************************************
	// Back checks
	// ****************************************
	// The ROM, vector, self-check and RAM selects each trace back to an access inside their own region
	property p_rom_back;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		ROM_SEL_O |->
			$past(ACCESS_I) && $past(ADDR_I) >= ROM_LO && $past(ADDR_I) <= ROM_HI;
	endproperty
	a_rom_back: assert property (p_rom_back) else $error("rom selected outside rom");

	property p_vec_back;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		VEC_SEL_O |->
			$past(ACCESS_I) && $past(ADDR_I) >= VEC_LO && $past(ADDR_I) <= VEC_HI;
	endproperty
	a_vec_back: assert property (p_vec_back) else $error("vectors selected outside area");

	property p_chk_back;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		CHK_SEL_O |->
			$past(ACCESS_I) && $past(ADDR_I) >= CHK_LO && $past(ADDR_I) <= CHK_HI;
	endproperty
	a_chk_back: assert property (p_chk_back) else $error("self-check selected outside");

	property p_ram_back;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		RAM_SEL_O |->
			$past(ACCESS_I) && $past(ADDR_I) >= RAM_LO && $past(ADDR_I) <= RAM_HI;
	endproperty
	a_ram_back: assert property (p_ram_back) else $error("ram selected outside ram");

	// ****************************************
	// Unmapped holes
	// ****************************************
	// Hole between I/O and RAM
	property p_hole;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		ACCESS_I && ADDR_I > IO_HI && ADDR_I < RAM_LO |=> ILLEGAL_O;
	endproperty
	a_hole: assert property (p_hole) else $error("hole not flagged");

	// Gap between RAM and user ROM
	property p_gap;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		ACCESS_I && ADDR_I > RAM_HI && ADDR_I < ROM_LO |=> ILLEGAL_O && !RAM_SEL_O;
	endproperty
	a_gap: assert property (p_gap) else $error("gap not flagged");

	// ****************************************
	// Stack checks
	// ****************************************
	// Leaving reset shows the top of the stack
	property p_sp_init;
		@(posedge CORE_CLK_I)
		$fell(RST_I) |-> SP_ADDR_O == {STACK_UPPER, SP_RESET};
	endproperty
	a_sp_init: assert property (p_sp_init) else $error("stack start wrong");

	// The output copy never leaves the window
	property p_sp_win;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		SP_ADDR_O >= STACK_BASE && SP_ADDR_O <= {STACK_UPPER, SP_RESET};
	endproperty
	a_sp_win: assert property (p_sp_win) else $error("stack outside window");

	// A reload shows the top of stack two edges later
	property p_sp_load;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		SP_OP_I == SP_LOAD |=> ##1 SP_ADDR_O == {STACK_UPPER, SP_RESET};
	endproperty
	a_sp_load: assert property (p_sp_load) else $error("reload missed top of stack");

	// A pop steps the offset up by one, wrapping inside the window
	property p_sp_pop;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		(SP_OP_I == SP_POP) |=> ##1
			(SP_ADDR_O[SP_OFS_W-1:0] == $past(SP_ADDR_O[SP_OFS_W-1:0]) + SP_ONE);
	endproperty
	a_sp_pop: assert property (p_sp_pop) else $error("pop did not step up");

	// ****************************************
	// Coverage
	// ****************************************
	c_rom: cover property (@(posedge CORE_CLK_I) ROM_SEL_O);
	c_vec: cover property (@(posedge CORE_CLK_I) VEC_SEL_O);
	c_ill: cover property (@(posedge CORE_CLK_I) ILLEGAL_O);
	c_push: cover property (@(posedge CORE_CLK_I) SP_ADDR_O == STACK_BASE);
	c_wrap: cover property (@(posedge CORE_CLK_I)
		(SP_ADDR_O == STACK_BASE) ##1 (SP_ADDR_O == {STACK_UPPER, SP_RESET}));
endmodule // memmap_decoder

// file: rtl/memmap_pkg.sv
/*
 * Memory map constants for the address decoder: region bounds,
 * stack window and widths.
 * Assumes a 13-bit CPU address bus and a 6-bit stack offset.
 */
package memmap_pkg;
	localparam int          ADDR_W        = 13;
	localparam int          SP_OFS_W      = 6;
	localparam logic [12:0] ROM_LO        = 13'h0b00;
	localparam logic [12:0] ROM_HI        = 13'h1eff;
	localparam logic [12:0] CHK_LO        = 13'h1f00;
	localparam logic [12:0] CHK_HI        = 13'h1fef;
	localparam logic [12:0] VEC_LO        = 13'h1ff0;
	localparam logic [12:0] VEC_HI        = 13'h1fff;
	localparam logic [12:0] RAM_LO        = 13'h0080;
	localparam logic [12:0] RAM_HI        = 13'h01ff;
	localparam logic [12:0] IO_LO         = 13'h0000;
	localparam logic [12:0] IO_HI         = 13'h001f;
	localparam logic [12:0] STACK_BASE    = 13'h00c0;
	localparam logic [5:0]  SP_RESET      = 6'h3f;
	localparam logic [5:0]  SP_ONE        = 6'h01;
	localparam logic [6:0]  STACK_UPPER   = 7'h03;

	typedef enum logic [1:0] {SP_HOLD, SP_PUSH, SP_POP, SP_LOAD} sp_op_type;

	// Inclusive range check
	function automatic logic in_range(input logic [12:0] a, input logic [12:0] lo,
		input logic [12:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction
endpackage

// file: rtl/stack_ptr.sv
/*
 * Stack pointer confined to the 64-byte stack window.
 * Assumes the core issues one push, pop or reset-stack per cycle.
 */
`timescale 1ns/1ns
module stack_ptr
	import memmap_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire sp_op_type        op_i,
	output logic [ADDR_W-1:0]     sp_addr_o
);
	logic [SP_OFS_W-1:0] ofs_q;
	logic [SP_OFS_W-1:0] ofs_d;

	// Only the low six bits move; wraps inside the window
	always_comb
	begin
		unique case (op_i)
			SP_HOLD: ofs_d = ofs_q;
			SP_PUSH: ofs_d = ofs_q - SP_ONE;
			SP_POP:  ofs_d = ofs_q + SP_ONE;
			SP_LOAD: ofs_d = SP_RESET;
		endcase
	end

	// Offset register
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			ofs_q <= SP_RESET;
		else
			ofs_q <= ofs_d;
	end

	// Fixed upper bits
	assign sp_addr_o = {STACK_UPPER, ofs_q};

	property p_sp_window;
		@(posedge clk_i) disable iff (rst_i)
		sp_addr_o[ADDR_W-1:SP_OFS_W] == STACK_UPPER;
	endproperty
	a_sp_window: assert property (p_sp_window) else $error("stack address left window");

	property p_sp_push;
		@(posedge clk_i) disable iff (rst_i)
		(op_i == SP_PUSH) |=>
			(sp_addr_o[SP_OFS_W-1:0] == $past(sp_addr_o[SP_OFS_W-1:0]) - SP_ONE);
	endproperty
	a_sp_push: assert property (p_sp_push) else $error("push did not step down");
endmodule // stack_ptr

// file: testbench/core_model.sv
/* Core side model: puts the bench's requests on the bus.
 * Assumes the bench posts requests on the clock edge. */
`timescale 1ns/1ns
module core_model
	import memmap_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic [ADDR_W-1:0] want_addr_i,
	input  wire logic              want_acc_i,
	input  wire sp_op_type         want_op_i,
	output logic [ADDR_W-1:0]      addr_o,
	output logic                   acc_o,
	output sp_op_type              op_o
);
	// Idle bus at start, then requests land 1 ns after each rising edge
	initial
	begin
		addr_o = '0;
		acc_o  = 1'b0;
		op_o   = SP_HOLD;
		forever
		begin
			@(posedge clk_i);
			#1;
			addr_o = want_addr_i;
			acc_o  = want_acc_i;
			op_o   = want_op_i;
		end
	end
endmodule // core_model

// file: testbench/tb_top.sv
/* Bench for the address decoder and stack window.
 * Assumes the core model adds a 1 ns launch delay. */
`timescale 1ns/1ns
module tb_top
	import memmap_pkg::*;
;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [12:0]       want_addr = 13'h0000;
	logic              want_acc = 1'b0;
	sp_op_type         want_op = SP_HOLD;
	logic [12:0]       addr, sp_addr, spx;
	logic              acc, rom, vec, chk, ram, io, ill;
	sp_op_type         op;
	int                err_total = 0;
	int                n_compared = 0;
	logic [31:0]       seed = 32'h429a;
	logic [12:0]       corner [14] = '{13'h0000, 13'h001f, 13'h0020, 13'h007f, 13'h0080,
		13'h01ff, 13'h0200, 13'h0aff, 13'h0b00, 13'h1eff, 13'h1f00, 13'h1fef, 13'h1ff0, 13'h1fff};

	core_model core_model_inst (.clk_i(clk), .want_addr_i(want_addr), .want_acc_i(want_acc),
		.want_op_i(want_op), .addr_o(addr), .acc_o(acc), .op_o(op));
	memmap_decoder memmap_decoder_inst (.CORE_CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
		.ACCESS_I(acc), .SP_OP_I(op), .ROM_SEL_O(rom), .VEC_SEL_O(vec), .CHK_SEL_O(chk),
		.RAM_SEL_O(ram), .IO_SEL_O(io), .ILLEGAL_O(ill), .SP_ADDR_O(sp_addr));

	// Clock and watchdog
	initial
	begin
		forever #25 clk = ~clk;
	end
	initial
	begin
		#200000;
		err_total++;
		conclude();
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction

	// Expected selects: rom, vec, chk, ram, io, illegal
	function automatic logic [5:0] exp_sel(input logic [12:0] a, input logic v);
		logic [4:0] r;
		r = {a >= 13'h0b00 && a <= 13'h1eff, a >= 13'h1ff0, a >= 13'h1f00 && a <= 13'h1fef,
			a >= 13'h0080 && a <= 13'h01ff, a <= 13'h001f};
		return v ? {r, r == 5'h00} : 6'h00;
	endfunction

	function automatic logic [12:0] sp_next(input logic [12:0] s, input sp_op_type o);
		case (o)
			SP_PUSH: return s == 13'h00c0 ? 13'h00ff : s - 13'h0001;
			SP_POP:  return s == 13'h00ff ? 13'h00c0 : s + 13'h0001;
			SP_LOAD: return 13'h00ff;
			default: return s;
		endcase
	endfunction

	task automatic cmp(input string nm, input logic [12:0] e, input logic [12:0] s);
		n_compared++;
		if (s !== e)
		begin
			err_total++;
			$display("mismatch %s exp %h got %h", nm, e, s);
		end
	endtask

	task automatic probe(input logic [12:0] a, input logic v);
		@(posedge clk);
		want_addr = a;
		want_acc = v;
		@(posedge clk);
		#2;
		cmp("selects", {7'h00, exp_sel(a, v)}, {7'h00, rom, vec, chk, ram, io, ill});
	endtask

	task automatic sp_step(input sp_op_type o);
		@(posedge clk);
		want_op = o;
		@(posedge clk);
		want_op = SP_HOLD;
		@(posedge clk);
		#2;
		spx = sp_next(spx, o);
		cmp("stack", spx, sp_addr);
	endtask

	task automatic conclude();
		if (err_total == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Reset, region corners, random addresses, stack walk
	initial
	begin
		repeat (16) @(posedge clk);
		#1;
		cmp("sp reset", 13'h00ff, sp_addr);
		rst = 1'b0;
		foreach (corner[i]) probe(corner[i], 1'b1);
		probe(13'h0b00, 1'b0);
		repeat (300)
		begin
			seed = xs(seed);
			probe(seed[12:0], seed[13]);
		end
		spx = 13'h00ff;
		for (int i = 0; i < 230; i++)
		begin
			seed = xs(seed);
			sp_step(i < 66 ? SP_PUSH : i < 134 ? SP_POP : sp_op_type'(seed[1:0]));
		end
		conclude();
	end
endmodule // tb_top
